// >>> cfa_front.sv
/*
  Camera frame acquisition front: window/ROI crop, binarization, tap placement,
  triggers, quadrature counter and camera control timing, Avalon-MM registers.
  Assumes the pixel clock is far slower than clock; it is sampled, not used.
*/
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module cfa_front
  import cfa_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic [cfa_pkg::CFA_ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire cfa_pkg::cfa_cam_s          cam,
  output cfa_pkg::cfa_pix_s               pix_out,
  input  wire logic [cfa_pkg::CFA_TRIG_N-1:0] trig_in,
  output logic      [cfa_pkg::CFA_TRIG_N-1:0] trig_out,
  output logic      [cfa_pkg::CFA_TRIG_N-1:0] trig_oe_n,
  input  wire logic                       enc_a,
  input  wire logic                       enc_b,
  output logic      [cfa_pkg::CFA_CC_N-1:0]   cc_out
);
  import cfa_pkg::*;

  // Register file
  logic [31:0] ctrl_reg, nfr_reg, win_h_reg, win_v_reg, roi_h_reg, roi_v_reg;
  logic [31:0] thr_reg, dir_reg, tcfg_reg, tsrc_reg, filt_reg, div_reg;
  logic [31:0] tper_reg [2];
  logic [31:0] twid_reg [2];
  logic [11:0] ccsrc_reg;
  logic [1:0]  ten_reg;
  logic        wait_reg, start_reg, stop_reg;
  logic [31:0] rdata_reg, enc_hi_reg, rd_mux;
  logic [63:0] enc_cnt_reg;
  logic [15:0] done_reg;
  cfa_acq_e    state_reg;
  logic        cfg_ok;

  wire req = avs_read | avs_write;
  wire acc = req & ~wait_reg;
  wire wr  = acc & avs_write;

  // One wait cycle, then answer; keeps read data a plain flop
  always_ff @(posedge clock) begin
    if (reset) wait_reg <= 1'b1;
    else       wait_reg <= ~(req & wait_reg);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_reg  <= CTRL_RST;
      nfr_reg   <= '0;
      win_h_reg <= WINDOW_RST;
      win_v_reg <= WINDOW_RST;
      roi_h_reg <= WINDOW_RST;
      roi_v_reg <= WINDOW_RST;
      thr_reg   <= '0;
      dir_reg   <= '0;
      tcfg_reg  <= '0;
      tsrc_reg  <= '0;
      filt_reg  <= '0;
      div_reg   <= '0;
      ccsrc_reg <= '0;
      ten_reg   <= '0;
      for (int i = 0; i < 2; i++) begin
        tper_reg[i] <= '0;
        twid_reg[i] <= '0;
      end
    end else if (wr) begin
      case (avs_address)
        REG_CTRL:     ctrl_reg  <= avs_writedata & ~32'h0000_0003;
        REG_NFRAMES:  nfr_reg   <= avs_writedata;
        REG_WIN_H:    win_h_reg <= avs_writedata;
        REG_WIN_V:    win_v_reg <= avs_writedata;
        REG_ROI_H:    roi_h_reg <= avs_writedata;
        REG_ROI_V:    roi_v_reg <= avs_writedata;
        REG_THRESH:   thr_reg   <= avs_writedata;
        REG_TAP_DIR:  dir_reg   <= avs_writedata;
        REG_TRIG_CFG: tcfg_reg  <= avs_writedata;
        REG_TRIG_SRC: tsrc_reg  <= avs_writedata;
        REG_FILTER:   filt_reg  <= avs_writedata;
        REG_ENC_DIV:  div_reg   <= avs_writedata;
        REG_CC_SRC:   ccsrc_reg <= avs_writedata[11:0];
        REG_TMR_EN:   ten_reg   <= avs_writedata[1:0];
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (avs_address == REG_TMR_PER0 + 5'(2 * i))
              tper_reg[i] <= avs_writedata;
            if (avs_address == REG_TMR_PER0 + 5'(2 * i + 1))
              twid_reg[i] <= avs_writedata;
          end
        end
      endcase
    end
  end

  // Start and stop are self-clearing command bits
  always_ff @(posedge clock) begin
    if (reset) begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end else begin
      start_reg <= wr && avs_address == REG_CTRL && avs_writedata[CTRL_START];
      stop_reg  <= wr && avs_address == REG_CTRL && avs_writedata[CTRL_STOP];
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      REG_CTRL:     rd_mux = ctrl_reg;
      REG_STATUS:   rd_mux = {12'h0, ~cfg_ok, state_reg, done_reg};
      REG_NFRAMES:  rd_mux = nfr_reg;
      REG_WIN_H:    rd_mux = win_h_reg;
      REG_WIN_V:    rd_mux = win_v_reg;
      REG_ROI_H:    rd_mux = roi_h_reg;
      REG_ROI_V:    rd_mux = roi_v_reg;
      REG_THRESH:   rd_mux = thr_reg;
      REG_TAP_DIR:  rd_mux = dir_reg;
      REG_TRIG_CFG: rd_mux = tcfg_reg;
      REG_TRIG_SRC: rd_mux = tsrc_reg;
      REG_FILTER:   rd_mux = filt_reg;
      REG_ENC_LO:   rd_mux = enc_cnt_reg[31:0];
      REG_ENC_HI:   rd_mux = enc_hi_reg;
      REG_ENC_DIV:  rd_mux = div_reg;
      REG_CC_SRC:   rd_mux = {20'h0, ccsrc_reg};
      REG_TMR_EN:   rd_mux = {30'h0, ten_reg};
      default: begin
        for (int i = 0; i < 2; i++) begin
          if (avs_address == REG_TMR_PER0 + 5'(2 * i)) rd_mux = tper_reg[i];
          if (avs_address == REG_TMR_PER0 + 5'(2 * i + 1)) rd_mux = twid_reg[i];
        end
      end
    endcase
  end

  // Low-word read freezes the high word so the 64-bit pair is coherent
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_reg  <= '0;
      enc_hi_reg <= '0;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= rd_mux;
      if (avs_address == REG_ENC_LO) enc_hi_reg <= enc_cnt_reg[63:32];
    end
  end
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // Camera link sampled by the system clock
  cfa_cam_s cam_s1_reg, cam_s2_reg;
  logic     clk_d_reg, lval_d_reg, fval_d_reg;
  always_ff @(posedge clock) begin
    cam_s1_reg <= cam;
    cam_s2_reg <= cam_s1_reg;
    clk_d_reg  <= cam_s2_reg.clk;
  end
  wire pe    = cam_s2_reg.clk & ~clk_d_reg;
  wire lrise = pe & cam_s2_reg.lval & ~lval_d_reg;
  wire lfall = pe & ~cam_s2_reg.lval & lval_d_reg;
  wire frise = pe & cam_s2_reg.fval & ~fval_d_reg;
  wire ffall = pe & ~cam_s2_reg.fval & fval_d_reg;

  // Beat and line counters; reset abandons any frame in flight
  logic [15:0] col_reg, row_reg;
  wire  [15:0] cur_col = lrise ? 16'h0 : col_reg;
  always_ff @(posedge clock) begin
    if (reset) begin
      lval_d_reg <= 1'b0;
      fval_d_reg <= 1'b0;
      col_reg    <= '0;
      row_reg    <= '0;
    end else if (pe) begin
      lval_d_reg <= cam_s2_reg.lval;
      fval_d_reg <= cam_s2_reg.fval;
      if (cam_s2_reg.lval) col_reg <= cur_col + 16'h1;
      if (frise) row_reg <= '0;
      else if (lfall) row_reg <= row_reg + 16'h1;
    end
  end

  // Window, then ROI relative to the window origin
  wire [15:0] cx  = cur_col - win_h_reg[15:0];
  wire [15:0] ry  = row_reg - win_v_reg[15:0];
  wire [15:0] cx2 = cx - roi_h_reg[15:0];
  wire [15:0] ry2 = ry - roi_v_reg[15:0];
  wire in_win = cur_col >= win_h_reg[15:0] && cx < win_h_reg[31:16]
             && row_reg >= win_v_reg[15:0] && ry < win_v_reg[31:16];
  wire in_roi = in_win && cx >= roi_h_reg[15:0] && cx2 < roi_h_reg[31:16]
             && ry >= roi_v_reg[15:0] && ry2 < roi_v_reg[31:16];
  wire beat_ok = pe && cam_s2_reg.fval && cam_s2_reg.lval && in_roi
              && state_reg == ACQ_RUN;

  // Legal arrangement, width and tap count combinations
  wire [1:0] arr = ctrl_reg[CTRL_ARR +: 2];
  wire [4:0] pw  = ctrl_reg[CTRL_PW +: 5];
  wire [3:0] nt  = ctrl_reg[CTRL_TAPS +: 4];
  wire pw_1012 = pw == 5'd10 || pw == 5'd12;
  always_comb begin
    case (cfa_arr_e'(arr))
      CFA_ARR_BASE: cfg_ok = (pw == 5'd8 && nt <= 4'd3) || (pw_1012 && nt <= 4'd2)
                          || ((pw == 5'd14 || pw == 5'd16) && nt == 4'd1);
      CFA_ARR_MEDIUM: cfg_ok = (pw == 5'd8 && nt == 4'd4)
                          || (pw_1012 && (nt == 4'd3 || nt == 4'd4));
      CFA_ARR_FULL: cfg_ok = pw == 5'd8 && nt == 4'd8;
      CFA_ARR_EXT:  cfg_ok = (pw == 5'd8 || pw == 5'd10) && nt == 4'd8;
      default:      cfg_ok = 1'b0;
    endcase
    if (nt == 4'd0) cfg_ok = 1'b0;
  end

  // Base sees port 0 only; standard arrangements 64 bits; extended all 80
  wire [CFA_DATA_W-1:0] data_m =
    arr == CFA_ARR_BASE ? cam_s2_reg.data & {{(CFA_DATA_W-CFA_BASE_W){1'b0}},
                                             {CFA_BASE_W{1'b1}}}
  : arr == CFA_ARR_EXT  ? cam_s2_reg.data
  : cam_s2_reg.data & {{(CFA_DATA_W-CFA_STD_W){1'b0}}, {CFA_STD_W{1'b1}}};
  wire [15:0] white = 16'((32'h1 << pw) - 32'h1);

  logic [CFA_TAPS-1:0][CFA_PIX_W-1:0] tap_out;
  logic [CFA_TAPS-1:0][CFA_CRD_W-1:0] tap_x, tap_y;
  logic [CFA_TAPS-1:0]                rng;
  for (genvar i = 0; i < CFA_TAPS; i++) begin : g_tap
    wire [CFA_DATA_W-1:0] sh  = data_m >> (i * pw);
    wire [15:0]           val = (4'(i) < nt) ? sh[15:0] & white : 16'h0;
    assign rng[i] = val >= thr_reg[15:0] && val <= thr_reg[31:16];
    // Inside interval is particle; inverse swaps particle and background
    assign tap_out[i] = !ctrl_reg[CTRL_BIN] ? val
                      : (rng[i] ^ ctrl_reg[CTRL_INV]) ? white : 16'h0;
    // Per-tap placement, mirrored across the ROI on either axis
    assign tap_x[i] = dir_reg[i] ? roi_h_reg[31:16] - 16'h1 - cx2 : cx2;
    assign tap_y[i] = dir_reg[8+i] ? roi_v_reg[31:16] - 16'h1 - ry2 : ry2;
  end

  // Output beat register
  always_ff @(posedge clock) begin
    if (reset) begin
      pix_out <= '0;
    end else begin
      pix_out.valid <= beat_ok;
      if (beat_ok) begin
        pix_out.frame_start <= cx2 == 16'h0 && ry2 == 16'h0;
        pix_out.data        <= tap_out;
        pix_out.x           <= tap_x;
        pix_out.y           <= tap_y;
      end
    end
  end

  // Trigger and encoder inputs, synchronised then filtered
  logic [CFA_FILT_N-1:0] clean;
  cfa_in_filter #(.W(CFA_FILT_N), .LEN_W(8)) u_filter (
    .clock    (clock),
    .reset    (reset),
    .raw      ({enc_b, enc_a, trig_in}),
    .filt_en  (filt_reg[CFA_FILT_N-1:0]),
    .filt_len (filt_reg[FILT_LEN +: 8]),
    .clean    (clean)
  );

  // Trigger edges after polarity; only input-direction lines may start
  logic [7:0] tlv_d_reg;
  wire  [7:0] tlv  = clean[7:0] ^ tcfg_reg[TCFG_POL +: 8];
  wire  [7:0] tedg = tcfg_reg[TCFG_RISE +: 8] & tlv & ~tlv_d_reg
                   | ~tcfg_reg[TCFG_RISE +: 8] & ~tlv & tlv_d_reg;
  wire trig_start = |(tedg & tcfg_reg[TCFG_EN +: 8] & ~tcfg_reg[TCFG_DIR +: 8]);
  always_ff @(posedge clock) begin
    if (reset) tlv_d_reg <= '0;
    else       tlv_d_reg <= tlv;
  end

  // Acquisition control
  always_ff @(posedge clock) begin
    if (reset || stop_reg) begin
      state_reg <= ACQ_IDLE;
    end else begin
      case (state_reg)
        ACQ_IDLE:  if ((start_reg || trig_start) && cfg_ok) state_reg <= ACQ_ARMED;
        ACQ_ARMED: if (frise) state_reg <= ACQ_RUN;
        ACQ_RUN:   if (ffall && nfr_reg[15:0] != 16'h0 && done_reg + 16'h1 >= nfr_reg[15:0])
                     state_reg <= ACQ_IDLE;
        default:   state_reg <= ACQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (reset || (state_reg == ACQ_IDLE && (start_reg || trig_start)))
      done_reg <= '0;
    else if (state_reg == ACQ_RUN && ffall)
      done_reg <= done_reg + 16'h1;
  end

  // Two counter timers: period and high width
  logic [31:0] tcnt_reg [2];
  logic [1:0]  tmr_out;
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    always_ff @(posedge clock) begin
      if (reset || !ten_reg[t])             tcnt_reg[t] <= '0;
      else if (tcnt_reg[t] + 32'h1 >= tper_reg[t]) tcnt_reg[t] <= '0;
      else                                  tcnt_reg[t] <= tcnt_reg[t] + 32'h1;
    end
    assign tmr_out[t] = ten_reg[t] && tcnt_reg[t] < twid_reg[t];
  end

  // Quadrature decode, one count per phase transition
  logic        a_d_reg, b_d_reg, enc_pls_reg;
  logic [31:0] tick_reg;
  wire enc_step = (clean[8] ^ a_d_reg) ^ (clean[9] ^ b_d_reg);
  wire enc_fwd  = a_d_reg ^ clean[9];
  always_ff @(posedge clock) begin
    if (reset) begin
      a_d_reg     <= 1'b0;
      b_d_reg     <= 1'b0;
      enc_cnt_reg <= '0;
      tick_reg    <= '0;
      enc_pls_reg <= 1'b0;
    end else begin
      a_d_reg     <= clean[8];
      b_d_reg     <= clean[9];
      enc_pls_reg <= 1'b0;
      if (enc_step) begin
        enc_cnt_reg <= enc_fwd ? enc_cnt_reg + 64'h1 : enc_cnt_reg - 64'h1;
        // Divide-by-zero behaves as divide-by-one
        if (tick_reg + 32'h1 >= div_reg) begin
          tick_reg    <= '0;
          enc_pls_reg <= 1'b1;
        end else begin
          tick_reg <= tick_reg + 32'h1;
        end
      end
    end
  end

  // Route timing and status onto trigger lines and camera controls
  wire [7:0] src_vec = {1'b0, state_reg == ACQ_RUN && cam_s2_reg.fval,
                        state_reg != ACQ_IDLE, enc_pls_reg, tmr_out, 1'b1, 1'b0};
  always_ff @(posedge clock) begin
    if (reset) begin
      trig_out  <= '0;
      trig_oe_n <= '1;
      cc_out    <= '0;
    end else begin
      for (int i = 0; i < CFA_TRIG_N; i++)
        trig_out[i] <= src_vec[tsrc_reg[3*i +: 3]] ^ tcfg_reg[TCFG_POL+i];
      trig_oe_n <= ~tcfg_reg[TCFG_DIR +: 8];
      for (int j = 0; j < CFA_CC_N; j++)
        cc_out[j] <= src_vec[ccsrc_reg[3*j +: 3]];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  bin_white_a: assert property (beat_ok && ctrl_reg[CTRL_BIN] && !ctrl_reg[CTRL_INV]
    && rng[0] && nt != 4'd0 |=> pix_out.data[0] == $past(white)) else $error("binarize white");
  inv_zero_a: assert property (beat_ok && ctrl_reg[CTRL_BIN] && ctrl_reg[CTRL_INV]
    && rng[0] |=> pix_out.data[0] == 16'h0) else $error("inverse not zero");
  roi_gate_a: assert property (pe && !in_roi |=> !pix_out.valid)
    else $error("pixel outside roi");
  run_only_a: assert property (pix_out.valid |-> $past(state_reg) == ACQ_RUN)
    else $error("pixel while idle");
  hwin_start_a: assert property (lrise && win_h_reg[15:0] != 16'h0 |=> !pix_out.valid)
    else $error("window start ignored");
  frame_stop_a: assert property (state_reg == ACQ_RUN && ffall && nfr_reg[15:0] != 16'h0
    && done_reg + 16'h1 == nfr_reg[15:0] |=> state_reg == ACQ_IDLE) else $error("no stop");
  trig_arm_a: assert property (state_reg == ACQ_IDLE && trig_start && cfg_ok
    && !stop_reg |=> state_reg == ACQ_ARMED) else $error("trigger lost");
  trig_drive_a: assert property (tcfg_reg[TCFG_DIR] && tsrc_reg[2:0] == SRC_HIGH
    |=> !trig_oe_n[0] && trig_out[0] == !$past(tcfg_reg[TCFG_POL])) else $error("drive");
  enc_up_a: assert property (enc_step && enc_fwd |=> enc_cnt_reg == $past(enc_cnt_reg) + 64'h1)
    else $error("encoder count");
  div_pulse_a: assert property (enc_pls_reg |-> $past(enc_step))
    else $error("pulse without tick");
  cc_map_a: assert property (ccsrc_reg[2:0] == SRC_TMR0 |=> cc_out[0] == $past(tmr_out[0]))
    else $error("camera control route");

  frame_done_c: cover property (state_reg == ACQ_RUN ##1 state_reg == ACQ_IDLE);
  enc_pulse_c:  cover property (enc_pls_reg);
  bin_beat_c:   cover property (pix_out.valid && ctrl_reg[CTRL_BIN]);
endmodule

// >>> cfa_pkg.sv
/*
  Shared constants, modes and carriers of the camera frame acquisition front.
  Assumes a single 125 MHz system clock; register index = Avalon word address.
*/
package cfa_pkg;
  localparam int CFA_DATA_W = 80;           // Widest arrangement
  localparam int CFA_STD_W  = 64;           // Medium/Full data bits
  localparam int CFA_BASE_W = 24;           // One port only
  localparam int CFA_TAPS   = 8;
  localparam int CFA_PIX_W  = 16;
  localparam int CFA_CRD_W  = 16;
  localparam int CFA_TRIG_N = 8;            // Seven sync bus lines plus front panel
  localparam int CFA_CC_N   = 4;
  localparam int CFA_FILT_N = 10;           // Triggers, then encoder A and B
  localparam int CFA_ADDR_W = 5;

  // Register word addresses
  localparam logic [4:0] REG_CTRL     = 5'h00;
  localparam logic [4:0] REG_STATUS   = 5'h01;
  localparam logic [4:0] REG_NFRAMES  = 5'h02;
  localparam logic [4:0] REG_WIN_H    = 5'h03;
  localparam logic [4:0] REG_WIN_V    = 5'h04;
  localparam logic [4:0] REG_ROI_H    = 5'h05;
  localparam logic [4:0] REG_ROI_V    = 5'h06;
  localparam logic [4:0] REG_THRESH   = 5'h07;
  localparam logic [4:0] REG_TAP_DIR  = 5'h08;
  localparam logic [4:0] REG_TRIG_CFG = 5'h09;
  localparam logic [4:0] REG_TRIG_SRC = 5'h0a;
  localparam logic [4:0] REG_FILTER   = 5'h0b;
  localparam logic [4:0] REG_ENC_LO   = 5'h0c;
  localparam logic [4:0] REG_ENC_HI   = 5'h0d;
  localparam logic [4:0] REG_ENC_DIV  = 5'h0e;
  localparam logic [4:0] REG_TMR_PER0 = 5'h0f; // Period, then width, per timer
  localparam logic [4:0] REG_CC_SRC   = 5'h13;
  localparam logic [4:0] REG_TMR_EN   = 5'h14;

  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_BIN   = 2;
  localparam int CTRL_INV   = 3;
  localparam int CTRL_ARR   = 4;            // 2 bits
  localparam int CTRL_PW    = 8;            // 5 bits, pixel width
  localparam int CTRL_TAPS  = 16;           // 4 bits, tap count
  localparam logic [31:0] CTRL_RST   = 32'h0001_0800;
  localparam logic [31:0] WINDOW_RST = 32'hffff_0000;
  localparam int TCFG_EN = 0, TCFG_RISE = 8, TCFG_POL = 16, TCFG_DIR = 24;
  localparam int FILT_LEN = 16;

  typedef enum logic [1:0] {
    CFA_ARR_BASE = 2'h0, CFA_ARR_MEDIUM = 2'h1, CFA_ARR_FULL = 2'h2, CFA_ARR_EXT = 2'h3
  } cfa_arr_e;

  // Output route codes for trigger lines and camera controls
  localparam logic [2:0] SRC_LOW = 3'h0, SRC_HIGH = 3'h1, SRC_TMR0 = 3'h2,
                         SRC_TMR1 = 3'h3, SRC_ENC = 3'h4, SRC_BUSY = 3'h5,
                         SRC_FRAME = 3'h6;

  typedef enum logic [2:0] {
    ACQ_IDLE = 3'b001, ACQ_ARMED = 3'b010, ACQ_RUN = 3'b100
  } cfa_acq_e;

  typedef struct packed {
    logic                  clk;
    logic                  fval;
    logic                  lval;
    logic [CFA_DATA_W-1:0] data;
  } cfa_cam_s;

  typedef struct packed {
    logic                                valid;
    logic                                frame_start;
    logic [CFA_TAPS-1:0][CFA_PIX_W-1:0]  data;
    logic [CFA_TAPS-1:0][CFA_CRD_W-1:0]  x;
    logic [CFA_TAPS-1:0][CFA_CRD_W-1:0]  y;
  } cfa_pix_s;
endpackage

// >>> cfa_in_filter.sv
/*
  Two-stage synchroniser and selectable glitch filter, one lane per input.
  Assumes raw inputs are asynchronous pins; length counts system clocks.
*/
`timescale 1ns/100ps
module cfa_in_filter #(
  parameter int W     = 10,
  parameter int LEN_W = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [W-1:0]     raw,
  input  wire logic [W-1:0]     filt_en,
  input  wire logic [LEN_W-1:0] filt_len,
  output logic      [W-1:0]     clean
);
  if (W < 1 || LEN_W < 1) begin : g_chk
    $error("cfa_in_filter: bad width");
  end

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  // Two flops before anything looks at a pin
  always_ff @(posedge clock) begin
    s1_reg <= raw;
    s2_reg <= s1_reg;
  end

  // Per lane: a new level must stand filt_len + 1 clocks to pass
  for (genvar i = 0; i < W; i++) begin : g_lane
    logic [LEN_W-1:0] cnt_reg;
    always_ff @(posedge clock) begin
      if (reset) begin
        cnt_reg  <= '0;
        clean[i] <= 1'b0;
      end else if (!filt_en[i] || s2_reg[i] == clean[i]) begin
        cnt_reg  <= '0;
        clean[i] <= s2_reg[i];
      end else if (cnt_reg >= filt_len) begin
        cnt_reg  <= '0;
        clean[i] <= s2_reg[i];
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// >>> cfa_cam_model.sv
/* Behavioural base camera: one frame per rise of go, one tap of 8 bits.
   Assumes the bench raises go only while busy is low. */
`timescale 1ns/100ps
module cfa_cam_model
  import cfa_pkg::*;
#(
  parameter int ROWS = 3,
  parameter int COLS = 4
) (
  input  wire logic       go,
  input  wire logic [7:0] pix,
  output cfa_cam_s        cam,
  output logic            busy
);
  // Data set on the low half, so it is stable at the rise
  task automatic beat(input logic l);
    #62.5 cam.clk = 1'b0;
    cam.lval = l;
    cam.data = l ? {72'h0, pix} : ~cam.data;
    #62.5 cam.clk = 1'b1;
  endtask
  // Pixel clock runs inside a frame and for one beat after it, then stands still
  initial begin
    cam = '0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      cam.fval = 1'b1;
      beat(1'b0);
      for (int r = 0; r < ROWS; r++) begin
        repeat (COLS) beat(1'b1);
        repeat (2) beat(1'b0);
      end
      cam.fval = 1'b0;
      beat(1'b0);
      busy = 1'b0;
    end
  end
endmodule

// >>> cfa_front_tb.sv
/* Self-checking bench of the acquisition front.
   Assumes the camera model beside it and a one-wait-state register bus. */
`timescale 1ns/100ps
module cfa_front_tb;
  import cfa_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        avs_waitrequest, busy, go = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lo, lfsr = 32'h1af3;
  logic [7:0]  trig_out, trig_oe_n, pix = 8'h00, exp_pix = 8'h00, trig = 8'h00;
  logic [2:0]  tl;
  logic [1:0]  dir = 2'h0;
  logic        te;
  logic [3:0]  cc_out;
  cfa_cam_s    cam;
  cfa_pix_s    pix_out;
  int          n_fail = 0, n_checks = 0, n_valid = 0, n, p, w, hi;
  always #4 clock = ~clock;
  cfa_front uut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cam(cam),
    .pix_out(pix_out), .trig_in(trig), .trig_out(trig_out), .trig_oe_n(trig_oe_n),
    .enc_a(enc_a), .enc_b(enc_b), .cc_out(cc_out));
  cfa_cam_model cam_i (.go(go), .pix(pix), .cam(cam), .busy(busy));
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Threshold interval is 0x40..0x80 inclusive, white is all ones
  function automatic logic [7:0] thr(input logic [7:0] v, input int inv);
    return ((v >= 8'h40 && v <= 8'h80) ^ inv[0]) ? 8'hff : 8'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) begin n_fail++; finish_test(); end
    @(posedge clock);
  endtask
  task automatic frame;
    int i;
    go <= 1'b1;
    for (i = 0; i < 1000 && busy !== 1'b1; i++) @(posedge clock);
    go <= 1'b0;
    for (i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clock);
    if (i == 1000) begin n_fail++; finish_test(); end
    repeat (10) @(posedge clock);
  endtask
  // Every accepted beat carries the thresholded tap value and its place
  always @(posedge clock) if (pix_out.valid === 1'b1) begin
    chk({16'h0, pix_out.data[0]}, {24'h0, exp_pix});
    chk(pix_out.x[0], dir[0] ? 1 - n_valid % 2 : n_valid % 2);
    chk(pix_out.y[0], dir[1] ? 32'hfffe - n_valid / 2 : n_valid / 2);
    chk(pix_out.frame_start, n_valid == 0);
    n_valid++;
  end
  initial begin #500000; n_fail++; finish_test(); end
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk({trig_oe_n, cc_out, 19'h0, avs_waitrequest}, {8'hff, 4'h0, 19'h0, 1'b1});
    bus(0, REG_CTRL, 0); chk(rd, CTRL_RST);
    bus(0, REG_WIN_V, 0); chk(rd, WINDOW_RST);
    bus(0, 5'h1f, 0); chk(rd, 32'h0);
    // All lines driven high through the route, polarity random
    lfsr = nxt(lfsr);
    bus(1, REG_TRIG_SRC, 32'h0024_9249);
    bus(1, REG_CC_SRC, 32'h0000_0249);
    bus(1, REG_TRIG_CFG, {8'hff, lfsr[7:0], 16'h0});
    repeat (2) @(posedge clock);
    chk({trig_out, trig_oe_n, cc_out}, {~lfsr[7:0], 8'h00, 4'hf});
    // Window keeps beats 1..3, region the last two of them; one frame per start
    bus(1, REG_WIN_H, {16'd3, 16'd1});
    bus(1, REG_ROI_H, {16'd2, 16'd1});
    bus(1, REG_THRESH, {16'h0080, 16'h0040});
    bus(1, REG_NFRAMES, 32'h1);
    for (int m = 0; m < 3; m++) begin
      lfsr = nxt(lfsr);
      pix <= (m == 0) ? 8'h40 : lfsr[7:0];
      exp_pix = thr((m == 0) ? 8'h40 : lfsr[7:0], m % 2);
      dir = lfsr[9:8];
      bus(1, REG_TAP_DIR, {16'h0, 7'h0, dir[1], 7'h0, dir[0]});
      bus(1, REG_CTRL, CTRL_RST | 32'h5 | (32'h8 * (m % 2)));
      n_valid = 0;
      frame();
      chk(n_valid, 6);
      n_valid = 0;
      frame();
      chk(n_valid, 0);
      bus(0, REG_STATUS, 0); chk(rd[18:16], 3'h1);
    end
    // Illegal tap count refuses start; medium four taps is legal
    bus(1, REG_CTRL, 32'h0004_0801);
    bus(0, REG_STATUS, 0);
    chk(rd[19:16], 4'h9);
    bus(1, REG_CTRL, 32'h0004_0810);
    bus(0, REG_STATUS, 0);
    chk(rd[19:16], 4'h1);
    bus(1, REG_CTRL, CTRL_RST | 32'h4);
    // Trigger line as input: wrong edge ignored, chosen edge arms
    lfsr = nxt(lfsr);
    tl = lfsr[2:0];
    te = lfsr[3];
    trig[tl] <= te;
    bus(1, REG_TRIG_CFG, {16'h0, {8{te}}, 8'h00});
    bus(1, REG_TRIG_CFG, {16'h0, {8{te}}, 8'h01 << tl});
    chk(trig_oe_n, 8'hff);
    trig[tl] <= ~te;
    repeat (10) @(posedge clock);
    bus(0, REG_STATUS, 0);
    chk(rd[18:16], 3'h1);
    trig[tl] <= te;
    repeat (10) @(posedge clock);
    bus(0, REG_STATUS, 0);
    chk(rd[18:16], 3'h2);
    n_valid = 0;
    frame();
    chk(n_valid, 6);
    // Timer 0 on camera control 0: width high cycles in every period
    lfsr = nxt(lfsr);
    p = 4 + lfsr[1:0];
    w = 1 + lfsr[3:2];
    bus(1, REG_TMR_PER0, p);
    bus(1, REG_TMR_PER0 + 5'h1, w);
    bus(1, REG_CC_SRC, {29'h0, SRC_TMR0});
    bus(1, REG_TMR_EN, 32'h1);
    hi = 0;
    for (int c = 0; c < 10 * p; c++) begin
      @(posedge clock);
      hi += cc_out[0];
    end
    chk(hi, 10 * w);
    // Quadrature steps, A leading
    lfsr = nxt(lfsr);
    n = 1 + lfsr[2:0];
    for (int k = 0; k < n; k++) begin
      if (k % 2 == 0) enc_a <= ~enc_a;
      else enc_b <= ~enc_b;
      repeat (10) @(posedge clock);
    end
    bus(0, REG_ENC_LO, 0);
    lo = rd;
    bus(0, REG_ENC_HI, 0);
    chk(lo[31] ? -lo : lo, n);
    chk(rd, {32{lo[31]}});
    // Same steps undone in reverse order count back to zero
    for (int k = n - 1; k >= 0; k--) begin
      if (k % 2 == 0) enc_a <= ~enc_a;
      else enc_b <= ~enc_b;
      repeat (10) @(posedge clock);
    end
    bus(0, REG_ENC_LO, 0);
    lo = rd;
    bus(0, REG_ENC_HI, 0);
    chk(lo, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
